/* fcca_appender.v */
// Frame checksum chunk appender with AXI4-Lite control registers
// Summary of operation
// - With checksum chunk enabled, every transmitted frame gets a checksum chunk.
// - Checksum is the XMODEM CRC-16.
// - CRC covers pixel data and other chunks, never the checksum itself.
// - Checksum chunk always follows all other chunks, last in frame.
// - Chunk enable is refused while chunk mode is off.
// - Chunk mode off disables all chunks, checksum included.
// - Soft reset command reinitializes logic while power stays on.
// - Soft reset discards all volatile settings.
// - After soft reset device drops off link, reappears later.
//
// Chosen here: the AXI4-Lite register port and the address map.
`include "fcca_defines.vh"
module fcca_appender (
  input wire clk,
  input wire rst_n,
  input wire [3:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [3:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire [7:0] inData,
  input wire inLast,
  input wire inValid,
  output reg inReady,
  output reg [7:0] outData,
  output reg outLast,
  output reg outValid,
  input wire outReady,
  output reg linkPresent
);
  function [15:0] crcByte;
    input [15:0] c;
    input [7:0] b;
    integer i;
    reg [15:0] x;
    begin
      x = c ^ {b, 8'h00};
      for (i = 0; i < 8; i = i + 1) begin
        if (x[15]) x = {x[14:0], 1'b0} ^ `FCCA_CRC_POLY;
        else x = {x[14:0], 1'b0};
      end
      crcByte = x;
    end
  endfunction

  // Kind decode shared by the enable write and the enable readback
  function isCsumKind;
    input [7:0] kind;
    begin
      isCsumKind = (kind == `FCCA_KIND_CSUM);
    end
  endfunction

  reg chunkModeOn_q;
  reg [7:0] chunkKindSelect_q;
  reg csumEnable_q;
  reg softRst_q;
  reg [3:0] rstCnt_q;
  reg awHeld_q;
  reg wHeld_q;
  reg [3:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg [15:0] crc_q;
  reg [1:0] phase_q;
  reg frameCsum_q;
  reg [7:0] crcLo_q;
  // Set while a frame is partly taken in
  reg inFrame_q;
  // Output buffer: two entries, so a one-cycle stall by the receiver
  // never costs a byte
  reg [7:0] bufData_q [0:1];
  reg bufLast_q [0:1];
  reg [1:0] bufCnt_q;
  reg bufWr_q;
  reg bufRd_q;
  reg [31:0] frameCnt_q;

  // Trailer phases: data, then checksum high byte, then low byte
  localparam PH_DATA = 2'h0;
  localparam PH_HI = 2'h1;
  localparam PH_LO = 2'h2;

  // Stream side is held in reset by either reset source
  wire live = rst_n && !softRst_q;
  wire doWrite = awHeld_q && wHeld_q && !bvalid;
  // A soft reset write closes the read port at once, not a cycle late
  wire softStart = doWrite && (awAddr_q == `FCCA_ADDR_CTRL) && wStrb_q[0] &&
    wData_q[`FCCA_CTRL_RESET];
  wire bufFull = (bufCnt_q == 2'h2);
  wire bufEmpty = (bufCnt_q == 2'h0);
  reg pushV;
  reg [7:0] pushD;
  reg pushL;
  wire push = pushV && !bufFull;
  wire pop = !bufEmpty && (!outValid || outReady);

  // Selects what enters the buffer in each phase
  always @* begin
    pushV = 1'b0;
    pushD = 8'h00;
    pushL = 1'b0;
    case (phase_q)
      PH_DATA: begin
        pushV = inValid && inReady;
        pushD = inData;
        pushL = inLast && !frameCsum_q;
      end
      PH_HI: begin
        pushV = 1'b1;
        pushD = crc_q[15:8];
      end
      PH_LO: begin
        pushV = 1'b1;
        pushD = crcLo_q;
        pushL = 1'b1;
      end
      default: begin
        pushV = 1'b0;
      end
    endcase
  end

  // Register bus and settings; soft reset wipes everything volatile
  always @(posedge clk) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `FCCA_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `FCCA_RESP_OKAY;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 4'h0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      chunkModeOn_q <= 1'b0;
      chunkKindSelect_q <= 8'h00;
      csumEnable_q <= 1'b0;
      softRst_q <= 1'b0;
      rstCnt_q <= 4'h0;
      linkPresent <= 1'b1;
    end else begin
      // Readies toggle: each handshake costs two cycles, but the logic
      // needs no skid register on the address or data side
      awready <= !awHeld_q && !awready && !softRst_q;
      wready <= !wHeld_q && !wready && !softRst_q;
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (bvalid && bready) bvalid <= 1'b0;
      // The countdown keeps the link absent long enough to look like a
      // removal to the host; settings are held cleared the whole time
      if (softRst_q) begin
        chunkModeOn_q <= 1'b0;
        chunkKindSelect_q <= 8'h00;
        csumEnable_q <= 1'b0;
        rstCnt_q <= rstCnt_q - 4'h1;
        if (rstCnt_q == 4'h1) begin
          softRst_q <= 1'b0;
          linkPresent <= 1'b1;
        end
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `FCCA_RESP_OKAY;
        case (awAddr_q)
          `FCCA_ADDR_CTRL: if (wStrb_q[0]) begin
            chunkModeOn_q <= wData_q[`FCCA_CTRL_MODE];
            if (!wData_q[`FCCA_CTRL_MODE]) csumEnable_q <= 1'b0;
            if (wData_q[`FCCA_CTRL_RESET]) begin
              softRst_q <= 1'b1;
              rstCnt_q <= `FCCA_RST_CYCLES;
              linkPresent <= 1'b0;
            end
          end
          `FCCA_ADDR_SEL: if (wStrb_q[0]) chunkKindSelect_q <= wData_q[7:0];
          `FCCA_ADDR_EN: if (wStrb_q[0]) begin
            // Enable lands on the selected kind only; refused w/o mode
            if (!chunkModeOn_q) bresp <= `FCCA_RESP_SLVERR;
            else if (isCsumKind(chunkKindSelect_q))
              csumEnable_q <= wData_q[0];
          end
          `FCCA_ADDR_STAT: bresp <= `FCCA_RESP_OKAY;
          default: bresp <= `FCCA_RESP_SLVERR;
        endcase
      end
      // A read is refused for the whole soft reset, as writes are
      arready <= !arready && !rvalid && !softRst_q && !softStart;
      if (rvalid && rready) rvalid <= 1'b0;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= `FCCA_RESP_OKAY;
        case (araddr)
          `FCCA_ADDR_CTRL: rdata <= {31'h0, chunkModeOn_q};
          `FCCA_ADDR_SEL: rdata <= {24'h000000, chunkKindSelect_q};
          `FCCA_ADDR_EN: rdata <= {31'h0,
            isCsumKind(chunkKindSelect_q) && csumEnable_q};
          `FCCA_ADDR_STAT: rdata <= {frameCnt_q[15:0], crc_q};
          default: begin
            rdata <= 32'h00000000;
            rresp <= `FCCA_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Stream path: CRC, trailing checksum bytes, two-entry buffer
  always @(posedge clk) begin
    if (!live) begin
      crc_q <= `FCCA_CRC_INIT;
      phase_q <= PH_DATA;
      frameCsum_q <= 1'b0;
      inFrame_q <= 1'b0;
      crcLo_q <= 8'h00;
      bufCnt_q <= 2'h0;
      bufWr_q <= 1'b0;
      bufRd_q <= 1'b0;
      inReady <= 1'b0;
      outValid <= 1'b0;
      outData <= 8'h00;
      outLast <= 1'b0;
      frameCnt_q <= 32'h00000000;
      bufData_q[0] <= 8'h00;
      bufData_q[1] <= 8'h00;
      bufLast_q[0] <= 1'b0;
      bufLast_q[1] <= 1'b0;
    end else begin
      // Ready is taken down a cycle early, since it comes from a flop
      inReady <= (phase_q == PH_DATA) && (bufCnt_q == 2'h0 ||
        (bufCnt_q == 2'h1 && (pop || !push))) &&
        !(inValid && inReady && inLast);
      case (phase_q)
        PH_DATA: if (push) begin
          crc_q <= crcByte(crc_q, inData);
          inFrame_q <= !inLast;
          if (inLast) begin
            // Count wraps silently; only the low half is visible
            frameCnt_q <= frameCnt_q + 32'h00000001;
            if (frameCsum_q) phase_q <= PH_HI;
            else crc_q <= `FCCA_CRC_INIT;
          end
        end
        PH_HI: if (push) begin
          crcLo_q <= crc_q[7:0];
          phase_q <= PH_LO;
        end
        PH_LO: if (push) begin
          crc_q <= `FCCA_CRC_INIT;
          phase_q <= PH_DATA;
        end
        default: phase_q <= PH_DATA;
      endcase
      // Sampled only between frames, so a frame is never half-trailed;
      // a zero running CRC is no proof of a frame start, hence the flag
      if (phase_q == PH_DATA && !inFrame_q && !push)
        frameCsum_q <= chunkModeOn_q && csumEnable_q;
      if (push) begin
        bufData_q[bufWr_q] <= pushD;
        bufLast_q[bufWr_q] <= pushL;
        bufWr_q <= !bufWr_q;
      end
      if (pop) begin
        outData <= bufData_q[bufRd_q];
        outLast <= bufLast_q[bufRd_q];
        outValid <= 1'b1;
        bufRd_q <= !bufRd_q;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      bufCnt_q <= bufCnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // fcca_appender

/* fcca_defines.vh */
// Constants for the frame checksum chunk appender
`ifndef FCCA_DEFINES_VH
`define FCCA_DEFINES_VH
`define FCCA_ADDR_CTRL 4'h0
`define FCCA_ADDR_SEL 4'h4
`define FCCA_ADDR_EN 4'h8
`define FCCA_ADDR_STAT 4'hC
`define FCCA_CTRL_MODE 0
`define FCCA_CTRL_RESET 1
`define FCCA_KIND_CSUM 8'h01
`define FCCA_CRC_POLY 16'h1021
`define FCCA_CRC_INIT 16'h0000
`define FCCA_RESP_OKAY 2'h0
`define FCCA_RESP_SLVERR 2'h2
`define FCCA_RST_CYCLES 4'hF
`endif

/* fcca_appender_sva.sv */
// Port assertions for the frame checksum chunk appender
module fcca_appender_sva (
  input wire clk, rst_n, awready, wvalid, wready, bvalid, bready,
  input wire arvalid, arready, rvalid, rready, outLast, outValid,
  input wire outReady, linkPresent,
  input wire [1:0] bresp,
  input wire [31:0] rdata,
  input wire [7:0] outData
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  out_hold_a: assert property (outValid && !outReady && linkPresent |=>
    outValid && $stable({outData, outLast})) else $error("out dropped");
  b_hold_a: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("b dropped");
  r_hold_a: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("r dropped");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("late read");
  wr_answer_a: assert property (wvalid && wready |-> ##[1:4] bvalid)
    else $error("late write");
  link_low_a: assert property ($fell(linkPresent) |->
    !linkPresent [*8]) else $error("link back early");
  link_back_a: assert property ($fell(linkPresent) |->
    ##[1:16] linkPresent) else $error("link not back");
  // Soft reset must not answer the bus while settings are cleared
  bus_quiet_a: assert property (!linkPresent |->
    !awready && !wready && !arready) else $error("bus in reset");
  cover property (outValid && outReady && outLast);
  cover property ($fell(linkPresent));
  cover property (bvalid && bready && bresp == 2'h2);
endmodule // fcca_appender_sva
bind fcca_appender fcca_appender_sva chk (.clk, .rst_n, .awready, .wvalid,
  .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready,
  .outLast, .outValid, .outReady, .linkPresent, .bresp, .rdata, .outData);

/* fcca_host_model.sv */
// Host model: takes frames, rechecks the checksum residue
`include "fcca_defines.vh"
module fcca_host_model (
  input wire clk, rst_n, outLast, outValid, slow,
  input wire [7:0] outData,
  output reg outReady,
  output reg good_q,
  output reg [7:0] len_q, frames_q,
  output reg [15:0] tail_q
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [15:0] crc_q;
  reg [7:0] cnt_q;
  function [15:0] crcNext(input [15:0] c, input [7:0] b);
    integer i;
    begin
      crcNext = c ^ {b, 8'h00};
      for (i = 0; i < 8; i = i + 1)
        crcNext = crcNext[15] ? (crcNext << 1) ^ `FCCA_CRC_POLY : crcNext << 1;
    end
  endfunction
  always @(posedge clk) begin
    if (!rst_n) begin
      {outReady, good_q, len_q, frames_q, tail_q} <= 'h0;
      {crc_q, cnt_q} <= 'h0;
    end else begin
      // Slow mode stalls every other cycle to fill the design's buffer
      outReady <= slow ? ~outReady : 1'h1;
      if (outValid && outReady) begin
        tail_q <= {tail_q[7:0], outData};
        crc_q <= outLast ? 16'h0000 : crcNext(crc_q, outData);
        cnt_q <= outLast ? 8'h00 : cnt_q + 8'h01;
        if (outLast) begin
          len_q <= cnt_q + 8'h01;
          // Residue over data plus big-endian checksum is zero when good
          good_q <= crcNext(crc_q, outData) == 16'h0000;
          frames_q <= frames_q + 8'h01;
        end
      end
    end
  end
endmodule // fcca_host_model

/* fcca_testbench.sv */
// Testbench: register, stream and soft reset scenarios
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, inLast = 0, inValid = 0, slow = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [7:0] inData = 0;
  wire awready, wready, bvalid, arready, rvalid, inReady, outValid;
  wire outLast, outReady, linkPresent, good_q;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] outData, len_q, frames_q;
  wire [15:0] tail_q;
  int err_total = 0, num_checks = 0, lowTotal = 0;
  fcca_appender DUT (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .inData,
    .inLast, .inValid, .inReady, .outData, .outLast, .outValid,
    .outReady, .linkPresent);
  fcca_host_model host (.clk, .rst_n, .outData, .outLast, .outValid,
    .outReady, .slow, .len_q, .tail_q, .good_q, .frames_q);
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (rst_n && !linkPresent) lowTotal <= lowTotal + 1;
  task end_of_test;
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) err_total++;
    if (got !== exp) $display("mismatch at %0t: %h not %h", $time, got, exp);
  endtask
  task tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 300) err_total++;
    if (n > 300) end_of_test;
  endtask
  task wr(input [3:0] a, input [31:0] d, input [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      tick(n);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1);
    bready <= 0;
    chk(bresp, r);
    @(posedge clk);
  endtask
  task rd(input [3:0] a, input [31:0] d, input [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      tick(n);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1);
    rready <= 0;
    chk(rdata, d);
    chk(rresp, r);
    @(posedge clk);
  endtask
  // Sends the nine bytes 0x31..0x39 and waits for the host to see the end
  task frame(input [7:0] len, input [15:0] tl);
    int n;
    logic [7:0] f;
    f = frames_q;
    for (int i = 0; i < 9; i++) begin
      inData <= 8'h31 + 8'(i);
      inLast <= i == 8;
      inValid <= 1;
      n = 0;
      do tick(n); while (inReady !== 1);
    end
    inValid <= 0;
    n = 0;
    while (frames_q === f) tick(n);
    chk(len_q, len);
    chk(tail_q, tl);
    chk(good_q, len == 8'hB);
  endtask
  task s_refuse;
    wr(4'h8, 1, 2'h2);
    rd(4'h8, 0, 2'h0);
  endtask
  task s_checksum;
    wr(4'h0, 1, 2'h0);
    wr(4'h4, 1, 2'h0);
    wr(4'h8, 1, 2'h0);
    rd(4'h8, 1, 2'h0);
    frame(8'hB, 16'h31C3);
    slow <= 1;
    frame(8'hB, 16'h31C3);
    slow <= 0;
  endtask
  task s_mode_off;
    wr(4'h0, 0, 2'h0);
    frame(8'h9, 16'h3839);
    rd(4'hC, 32'h00030000, 2'h0);
  endtask
  task s_soft_reset;
    wr(4'h0, 1, 2'h0);
    wr(4'h4, 1, 2'h0);
    wr(4'h0, 3, 2'h0);
    repeat (30) @(posedge clk);
    chk(lowTotal, 15);
    rd(4'h0, 0, 2'h0);
    rd(4'h4, 0, 2'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    s_refuse;
    s_checksum;
    s_mode_off;
    s_soft_reset;
    end_of_test;
  end
endmodule // testbench
